/* src/hss_regs.svh */
// strap sampler constants: timing, field positions, reset values
// assumes a 25 MHz system clock and the hss_pkg types
// Summary of operation
// R01 - interface strap low picks spi, high i2c
// R02 - unselected port becomes diagnostic monitor port
// R03 - phase strap low mode 0/3, high 1/2
// R04 - spi mode applies to either spi role
// R05 - integrity strap low crc8, high checksum8
// R06 - integrity choice only on command port
// R07 - monitor port integrity comes from flash
// R08 - straps undriven in reset, sampled 1.5us after
// R09 - debug drive only after sampling completes
// R10 - weak pull-down makes open strap low
// R11 - low reset holds, rising edge starts config
// R12 - latched straps held until next reset
`ifndef HSS_REGS_SVH
`define HSS_REGS_SVH

// ==========================================================================
// timing
`define HSS_CLK_PERIOD_PS    40000
`define HSS_SAMPLE_DELAY_PS  1500000
// longest time, round down, never below one cycle
`define HSS_SAMPLE_CYCLES    ((`HSS_SAMPLE_DELAY_PS / `HSS_CLK_PERIOD_PS) < 1 ? \
                              1 : (`HSS_SAMPLE_DELAY_PS / `HSS_CLK_PERIOD_PS))

// ==========================================================================
// strap vector fields and reset values
`define HSS_STRAP_W          3
`define HSS_BIT_IFSEL        0
`define HSS_BIT_SPIMODE      1
`define HSS_BIT_INTEG        2
`define HSS_STRAP_RST        3'h0

`endif

/* src/hss_pkg.sv */
// types for the host interface strap sampler
// assumes nothing beyond a SystemVerilog tool
`default_nettype none
package hss_pkg;
  // gray coded along wait, count, done
  typedef enum logic [1:0] {
    HSS_WAIT  = 2'b00,
    HSS_COUNT = 2'b01,
    HSS_DONE  = 2'b11
  } hss_state_e;

  typedef enum logic {
    HSS_PORT_SPI = 1'b0,
    HSS_PORT_I2C = 1'b1
  } hss_port_e;

  typedef enum logic {
    HSS_INTEG_CRC8 = 1'b0,
    HSS_INTEG_SUM8 = 1'b1
  } hss_integ_e;
endpackage
`default_nettype wire

/* src/hss_strap_if.sv */
// carries sample strobe and sampled flag between sampler modules
// assumes a single clock domain
`default_nettype none
interface hss_strap_if;
  logic       sampleStb;
  logic       sampled;
  // latched straps stay local to the top, the timer never needs them
  modport timer (output sampleStb, output sampled);
  modport latch (input sampleStb, input sampled);
endinterface
`default_nettype wire

/* src/hss_sample_timer.sv */
// counts from reset release to the strap sampling instant
// assumes reset is applied asynchronously, clock is sys_clk
`include "hss_regs.svh"
`default_nettype none
module hss_sample_timer
  import hss_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `HSS_SAMPLE_CYCLES
) (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  // towards the latch
  hss_strap_if.timer  strapBus
);
  localparam int CW = $clog2(SAMPLE_CYCLES + 1);

  hss_state_e    state_r;
  logic [CW-1:0] count_r;

  // ========================================================================
  // sampling delay
  // R11 - release starts timing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= HSS_WAIT;
      count_r <= '0;
    end else begin
      case (state_r)
        HSS_WAIT: begin
          state_r <= HSS_COUNT;
          count_r <= CW'(1);
        end
        HSS_COUNT: begin
          // R08 - sample after delay
          if (count_r >= CW'(SAMPLE_CYCLES - 1)) begin
            state_r <= HSS_DONE;
          end else begin
            count_r <= count_r + CW'(1);
          end
        end
        HSS_DONE: state_r <= HSS_DONE;
        default:  state_r <= HSS_WAIT;
      endcase
    end
  end

  assign strapBus.sampleStb = (state_r == HSS_COUNT) && (count_r >= CW'(SAMPLE_CYCLES - 1));
  assign strapBus.sampled   = (state_r == HSS_DONE);
endmodule
`default_nettype wire

/* src/hss_strap_sampler.sv */
// top: samples host interface straps and routes port roles
// assumes strap pins are synchronous to sys_clk and pulled down
`include "hss_regs.svh"
`default_nettype none
module hss_strap_sampler
  import hss_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `HSS_SAMPLE_CYCLES
) (
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  nrst,
  // strap pins, three-signal form
  input  wire logic  hostIfSelIn,
  output logic       hostIfSelOut,
  output logic       hostIfSelOe_n,
  input  wire logic  spiModeIn,
  output logic       spiModeOut,
  output logic       spiModeOe_n,
  input  wire logic  linkIntegritySelectStrapIn,
  output logic       linkIntegritySelectStrapOut,
  output logic       linkIntegritySelectStrapOe_n,
  // debug drive request after sampling
  input  wire logic  debugEn,
  input  wire logic [2:0] debugVal,
  // flash-held monitor port integrity
  input  wire logic  flashMonInteg,
  // configuration results
  output logic       strapsValid,
  output logic       cmdPortI2c,
  output logic       cmdOnSpi,
  output logic       cmdOnI2c,
  output logic       monOnSpi,
  output logic       monOnI2c,
  output logic       spiModeAlt,
  output logic       cmdIntegSum,
  output logic       monIntegSum,
  output logic       spiIntegSum,
  output logic       i2cIntegSum
);
  hss_strap_if strapBus ();

  logic [`HSS_STRAP_W-1:0] strap_r;
  logic                    valid_r;
  logic                    dbgEn_r;
  logic [2:0]              dbgVal_r;
  logic                    monInteg_r;

  hss_sample_timer #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_timer (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .strapBus (strapBus)
  );

  // ========================================================================
  // strap latch
  // R12 - latch once, hold
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strap_r <= `HSS_STRAP_RST;
      valid_r <= 1'b0;
    end else if (strapBus.sampleStb && !valid_r) begin
      // R10 - open pin reads low
      strap_r[`HSS_BIT_IFSEL]   <= hostIfSelIn;
      strap_r[`HSS_BIT_SPIMODE] <= spiModeIn;
      strap_r[`HSS_BIT_INTEG]   <= linkIntegritySelectStrapIn;
      valid_r                   <= 1'b1;
    end
  end
  // ========================================================================
  // flash setting for the monitor port, followed every cycle once sampled
  // R07 - monitor integrity from flash
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      monInteg_r <= 1'b0;
    end else if (strapBus.sampled) begin
      monInteg_r <= flashMonInteg;
    end
  end

  // ========================================================================
  // debug drive of strap pins
  // R09 - drive only after sampling
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dbgEn_r  <= 1'b0;
      dbgVal_r <= 3'h0;
    end else begin
      dbgEn_r  <= debugEn && valid_r;
      dbgVal_r <= debugVal;
    end
  end

  // R08 - undriven until sampled
  assign hostIfSelOe_n               = !dbgEn_r;
  assign spiModeOe_n                 = !dbgEn_r;
  assign linkIntegritySelectStrapOe_n = !dbgEn_r;
  assign hostIfSelOut                = dbgVal_r[`HSS_BIT_IFSEL];
  assign spiModeOut                  = dbgVal_r[`HSS_BIT_SPIMODE];
  assign linkIntegritySelectStrapOut = dbgVal_r[`HSS_BIT_INTEG];

  // ========================================================================
  // port roles and protocol settings
  // cmdOn/monOn role results gated by valid; cmdPortI2c, mode and integrity outputs show reset defaults until sampled
  assign strapsValid = valid_r;
  // R01 - low spi, high i2c
  assign cmdPortI2c  = (hss_port_e'(strap_r[`HSS_BIT_IFSEL]) == HSS_PORT_I2C);
  assign cmdOnSpi    = valid_r && !cmdPortI2c;
  assign cmdOnI2c    = valid_r && cmdPortI2c;
  // R02 - other port monitors
  assign monOnSpi    = valid_r && cmdPortI2c;
  assign monOnI2c    = valid_r && !cmdPortI2c;
  // R03 - spi mode family
  // R04 - any spi role
  assign spiModeAlt  = strap_r[`HSS_BIT_SPIMODE];
  // R05 - crc8 or checksum8
  assign cmdIntegSum = (hss_integ_e'(strap_r[`HSS_BIT_INTEG]) == HSS_INTEG_SUM8);
  assign monIntegSum = monInteg_r;
  // R06 - strap only on command port
  assign spiIntegSum = cmdOnSpi ? cmdIntegSum : monInteg_r;
  assign i2cIntegSum = cmdOnI2c ? cmdIntegSum : monInteg_r;
endmodule
`default_nettype wire

/* verif/hss_strap_sva.sv */
// checker on the strap sampler top ports
// assumes one clock, async low reset
`include "hss_regs.svh"
`default_nettype none
module hss_strap_sva #(parameter int SAMPLE_CYCLES = `HSS_SAMPLE_CYCLES) (
  input wire logic sys_clk, nrst, hostIfSelIn, spiModeIn, linkIntegritySelectStrapIn, debugEn,
  input wire logic flashMonInteg, hostIfSelOe_n, strapsValid, cmdPortI2c, spiModeAlt,
  input wire logic cmdIntegSum, monIntegSum, i2cIntegSum);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ================
  // edges since release, saturates
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst) cnt_r <= 0;
    else if (cnt_r < SAMPLE_CYCLES) cnt_r <= cnt_r + 1;
  sequence s_latch; $rose(strapsValid); endsequence
  sequence s_held; strapsValid && $past(strapsValid); endsequence
  chk_sample_edge: assert property (strapsValid == (cnt_r >= SAMPLE_CYCLES))
    else $error("wrong sample edge");
  chk_ifsel_latch: assert property (s_latch |-> cmdPortI2c == $past(hostIfSelIn))
    else $error("port select lost");
  chk_mode_latch: assert property (s_latch |-> spiModeAlt == $past(spiModeIn))
    else $error("spi mode lost");
  chk_integ_latch: assert property (s_latch |-> cmdIntegSum == $past(linkIntegritySelectStrapIn))
    else $error("integrity lost");
  chk_i2c_integ: assert property (strapsValid |-> i2cIntegSum == (cmdPortI2c ? cmdIntegSum : monIntegSum))
    else $error("i2c integrity source");
  chk_mon_flash: assert property (s_held |-> monIntegSum == $past(flashMonInteg))
    else $error("monitor integrity source");
  chk_drive_gate: assert property (hostIfSelOe_n != $past(strapsValid && debugEn))
    else $error("pin drive gating");
  chk_hold_latch: assert property (s_held |-> $stable({cmdPortI2c, spiModeAlt, cmdIntegSum}))
    else $error("latched straps moved");
endmodule
bind hss_strap_sampler hss_strap_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_hss_strap_sva (.sys_clk, .nrst,
  .hostIfSelIn, .spiModeIn, .linkIntegritySelectStrapIn, .debugEn, .flashMonInteg, .hostIfSelOe_n,
  .strapsValid, .cmdPortI2c, .spiModeAlt, .cmdIntegSum, .monIntegSum, .i2cIntegSum);
`default_nettype wire

/* verif/hss_board.sv */
// board: strap pull-ups over pad pull-downs
// assumes bit order ifsel, mode, integrity
`default_nettype none
module hss_board (
  input  wire logic [2:0] pullUp,
  input  wire logic [2:0] dOut,
  input  wire logic [2:0] dOe_n,
  output logic      [2:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pad reads resistor, open pin low
  assign pin = (dOut & ~dOe_n) | (pullUp & dOe_n);
endmodule
`default_nettype wire

/* verif/tb_hss_strap_sampler.sv */
// bench: strap rows, then early debug request and moved pins
// assumes SAMPLE_CYCLES shortened to 4
`default_nettype none
module tb_hss_strap_sampler;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 4;
  typedef struct {logic [2:0] fit; logic fl; logic [8:0] exp;} hss_row_s;
  hss_row_s rows[4] = '{'{3'h0, 1'h1, 9'h125}, '{3'h7, 1'h0, 9'h0d9}, '{3'h5, 1'h1, 9'h0cf}, '{3'h2, 1'h0, 9'h130}};
  logic sys_clk = 0, nrst = 0, debugEn = 0, flashMonInteg = 0, strapsValid;
  logic [2:0] pullUp = 0, debugVal = 0;
  // bitwise port drivers need nets
  wire logic [2:0] pin, dOut, dOe_n;
  wire logic [8:0] res;
  int failures = 0, n_compared = 0, cyc = 0;
  hss_strap_sampler #(.SAMPLE_CYCLES(SC)) u_hss_strap_sampler (.sys_clk, .nrst,
    .hostIfSelIn(pin[0]), .hostIfSelOut(dOut[0]), .hostIfSelOe_n(dOe_n[0]), .spiModeIn(pin[1]),
    .spiModeOut(dOut[1]), .spiModeOe_n(dOe_n[1]), .linkIntegritySelectStrapIn(pin[2]),
    .linkIntegritySelectStrapOut(dOut[2]), .linkIntegritySelectStrapOe_n(dOe_n[2]), .debugEn, .debugVal,
    .flashMonInteg, .strapsValid, .cmdPortI2c(), .cmdOnSpi(res[8]), .cmdOnI2c(res[7]), .monOnSpi(res[6]),
    .monOnI2c(res[5]), .spiModeAlt(res[4]), .cmdIntegSum(res[3]), .monIntegSum(res[2]), .spiIntegSum(res[1]),
    .i2cIntegSum(res[0]));
  hss_board u_hss_board (.pullUp, .dOut, .dOe_n, .pin);
  always #20 sys_clk = ~sys_clk;
  task automatic check(input logic [11:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // reset, release, step past the sampling edge
  task automatic boot(input logic [2:0] fit, input logic fl);
    @(negedge sys_clk) nrst = 0;
    pullUp = fit;
    flashMonInteg = fl;
    repeat (6) @(negedge sys_clk);
    check({res, dOe_n}, 12'h007);
    nrst = 1;
    repeat (SC - 1) @(negedge sys_clk);
    check(strapsValid, 12'h000);
    @(negedge sys_clk);
    check(strapsValid, 12'h001);
    @(negedge sys_clk);
  endtask
  // hang guard, runs need under 200 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 400) begin
      failures++;
      close_out();
    end
  end
  initial begin
    foreach (rows[i]) begin
      boot(rows[i].fit, rows[i].fl);
      check(res, rows[i].exp);
      $display("row %0d done", i);
    end
    // debug asked early must wait for sampling
    debugEn = 1;
    debugVal = 3'h5;
    boot(3'h2, 1'h0);
    check({dOe_n, pin}, 12'h005);
    flashMonInteg = 1;
    repeat (2) @(negedge sys_clk);
    check(res, 12'h135);
    $display("debug test done");
    close_out();
  end
endmodule
`default_nettype wire
